//--- bench/itd_far_end.sv
`timescale 1ns/1ps

// Model of the I/O side: issues DMA command cycles and failure events.
// Idle data lines show the inverse of the last value so stale data cannot pass; pulses drop to zero.
module itd_far_end (
    input  wire logic        mclk,             // Core clock.
    output logic             ca_valid,         // Command cycle pulse.
    output logic [1:0]       ca_len,           // Transfer length.
    output logic [29:0]      ca_addr,          // Longword address.
    output logic             ilk_fail,         // Interlock failure pulse.
    output logic             par_err,          // Parity error pulse.
    output logic             par_err_dma_read  // Parity hit DMA read data.
);
    initial
    begin
        ca_valid = 1'b0;
        ca_len = 2'h0;
        ca_addr = 30'h0000_0000;
        ilk_fail = 1'b0;
        par_err = 1'b0;
        par_err_dma_read = 1'b0;
    end

    // Keeping the strobe up for back-to-back commands avoids two writes in one step.
    task automatic cmd(input logic [1:0] l, input logic [29:0] a, input bit more);
        ca_valid = 1'b1;
        ca_len = l;
        ca_addr = a;
        @(posedge mclk);
        #1;
        if (!more)
        begin
            ca_valid = 1'b0;
            ca_len = ~l;
            ca_addr = ~a;
        end
    endtask

    task automatic ev(input bit ilk, input bit par, input bit dma);
        ilk_fail = ilk;
        par_err = par;
        par_err_dma_read = dma;
        @(posedge mclk);
        #1;
        ilk_fail = 1'b0;
        par_err = 1'b0;
        par_err_dma_read = ~dma;
    endtask
endmodule

//--- bench/tb_top.sv
`timescale 1ns/1ps

module tb_top;
    logic        mclk = 1'b0, rst_n = 1'b0, ns_wr = 1'b0, ns_rd = 1'b0, irq_req = 1'b0;
    logic        ns_rack, irq_tx_valid, ilk_flag, par_flag;
    logic        ca_valid, ilk_fail, par_err, par_err_dma_read;
    logic [7:0]  ns_addr = 8'h00;
    logic [31:0] ns_wdata = 32'h0000_0000, ns_rdata, seed = 32'h0001_06F3;
    logic [31:0] m_tgt = 32'h0000_0000, m_capt = 32'h0000_0000;
    logic [1:0]  ca_len;
    logic [29:0] ca_addr;
    logic [15:0] irq_tx_dest;
    bit          m_ilk, m_par, m_lk;
    int          errors = 0, n_checks = 0;

    always #5 mclk = ~mclk;

    itd_regs u_itd_regs (.mclk(mclk), .rst_n(rst_n), .ns_addr(ns_addr), .ns_wr(ns_wr),
        .ns_rd(ns_rd), .ns_wdata(ns_wdata), .ns_rdata(ns_rdata), .ns_rack(ns_rack),
        .ca_valid(ca_valid), .ca_len(ca_len), .ca_addr(ca_addr), .ilk_fail(ilk_fail),
        .par_err(par_err), .par_err_dma_read(par_err_dma_read), .irq_req(irq_req),
        .irq_tx_valid(irq_tx_valid), .irq_tx_dest(irq_tx_dest), .ilk_flag(ilk_flag),
        .par_flag(par_flag));

    itd_far_end u_itd_far_end (.mclk(mclk), .ca_valid(ca_valid), .ca_len(ca_len),
        .ca_addr(ca_addr), .ilk_fail(ilk_fail), .par_err(par_err),
        .par_err_dma_read(par_err_dma_read));

    // ------------------------------------------------------------------
    // Helpers and reference model
    // ------------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic tick;
        @(posedge mclk);
        #1;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            errors++;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ns_addr = a;
        ns_wdata = d;
        ns_wr = 1'b1;
        tick();
        ns_wr = 1'b0;
        ns_wdata = ~d;
        if (a == itd_pkg::OFS_TARGET_SEL)
            m_tgt = d;
        if (a == itd_pkg::OFS_ERR_FLAGS && d[2])
            m_ilk = 1'b0;
        if (a == itd_pkg::OFS_ERR_FLAGS && d[0])
            {m_par, m_lk} = 2'b00;
        tick();
    endtask

    task automatic rd(input logic [7:0] a);
        logic [31:0] e;
        e = (a == itd_pkg::OFS_TARGET_SEL) ? m_tgt : (a == itd_pkg::OFS_DMA_CAPT) ? m_capt :
            (a == itd_pkg::OFS_ERR_FLAGS) ? {29'h0, m_ilk, 1'b0, m_par} : 32'h0000_0000;
        ns_addr = a;
        ns_rd = 1'b1;
        tick();
        ns_rd = 1'b0;
        chk("ns_rack", 32'h0000_0001, 32'(ns_rack));
        chk("ns_rdata", e, ns_rdata);
        tick();
    endtask

    task automatic irq;
        irq_req = 1'b1;
        tick();
        irq_req = 1'b0;
        chk("irq_tx_valid", 32'h0000_0001, 32'(irq_tx_valid));
        chk("irq_tx_dest", 32'(m_tgt[15:0]), 32'(irq_tx_dest));
        tick();
        chk("irq_idle", 32'h0000_0000, {15'h0, irq_tx_valid, irq_tx_dest});
    endtask

    task automatic send(input logic [31:0] v, input bit more);
        u_itd_far_end.cmd(v[31:30], v[29:0], more);
        if (!(m_ilk || m_lk))
            m_capt = v;
    endtask

    task automatic fail(input bit ilk, input bit par, input bit dma);
        u_itd_far_end.ev(ilk, par, dma);
        m_ilk |= ilk;
        m_par |= par;
        m_lk |= par & dma;
        tick();
        chk("flags", {30'h0, m_ilk, m_par}, {30'h0, ilk_flag, par_flag});
    endtask

    task automatic results;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    initial
    begin
        repeat (10) @(posedge mclk);
        #1;
        rst_n = 1'b1;
        tick();
        rd(itd_pkg::OFS_TARGET_SEL);
        rd(itd_pkg::OFS_DMA_CAPT);
        rd(itd_pkg::OFS_ERR_FLAGS);
        irq();
        $display("test reset values done");
        for (int i = 0; i < 6; i++)
        begin
            seed = lfsr(seed);
            wr(itd_pkg::OFS_TARGET_SEL, seed);
            rd(itd_pkg::OFS_TARGET_SEL);
            irq();
        end
        for (int n = 0; n < 16; n++)
        begin
            wr(itd_pkg::OFS_TARGET_SEL, (seed & 32'hFFFF_0000) | (32'h0000_0001 << n));
            irq();
        end
        wr(itd_pkg::OFS_DMA_CAPT, ~m_capt);
        rd(itd_pkg::OFS_DMA_CAPT);
        rd(8'h44);
        $display("test target and refusals done");
        for (int i = 0; i < 4; i++)
        begin
            seed = lfsr(seed);
            send(seed, i < 3);
        end
        rd(itd_pkg::OFS_DMA_CAPT);
        $display("test capture done");
        fail(1'b1, 1'b0, 1'b0);
        send(lfsr(seed), 1'b0);
        rd(itd_pkg::OFS_DMA_CAPT);
        rd(itd_pkg::OFS_ERR_FLAGS);
        // The command follows the clear by one cycle, the earliest it may load.
        fork
            wr(itd_pkg::OFS_ERR_FLAGS, 32'h0000_0004);
            begin
                tick();
                seed = lfsr(lfsr(seed));
                send(seed, 1'b0);
            end
        join
        chk("ilk_flag", 32'h0000_0000, 32'(ilk_flag));
        rd(itd_pkg::OFS_DMA_CAPT);
        $display("test interlock done");
        for (int d = 1; d >= 0; d--)
        begin
            fail(1'b0, 1'b1, d[0]);
            seed = lfsr(seed);
            send(seed, 1'b0);
            rd(itd_pkg::OFS_DMA_CAPT);
            rd(itd_pkg::OFS_ERR_FLAGS);
            wr(itd_pkg::OFS_ERR_FLAGS, 32'h0000_0001);
            seed = lfsr(seed);
            send(seed, 1'b0);
            rd(itd_pkg::OFS_DMA_CAPT);
        end
        $display("test parity done");
        results();
    end

    // A hung run is cut short and counted as a mismatch.
    initial
    begin
        repeat (20000) @(posedge mclk);
        errors++;
        results();
    end
endmodule

//--- hw/itd_capture_reg.sv
`timescale 1ns/1ps

// Length and longword address of the most recent DMA command cycle.
module itd_capture_reg #(
    parameter int LEN_W  = 2,
    parameter int ADDR_W = 30
) (
    input  wire logic                    mclk,    // Core clock.
    input  wire logic                    rst_n,   // Asynchronous reset, active low.
    input  wire logic                    load,    // Load strobe, already gated by lock.
    input  wire logic [LEN_W-1:0]        len,     // Transfer length.
    input  wire logic [ADDR_W-1:0]       addr,    // Longword address.
    output logic      [LEN_W+ADDR_W-1:0] value    // Captured length and address.
);

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            value <= itd_pkg::CAPT_RST[LEN_W+ADDR_W-1:0];
        end
        else if (load)
        begin
            value <= {len, addr};
        end
    end

endmodule

//--- hw/itd_pkg.sv
package itd_pkg;

    // ------------------------------------------------------------------
    // Node-space register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_ERR_FLAGS  = 8'h40;
    localparam logic [7:0] OFS_TARGET_SEL = 8'h48;
    localparam logic [7:0] OFS_DMA_CAPT   = 8'h4C;

    // ------------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------------
    localparam int REG_W       = 32;
    localparam int NODE_CNT    = 16;
    localparam int LEN_W       = 2;
    localparam int ADDR_W      = 30;
    localparam int CAPT_LEN_LO = 30;
    localparam int ERR_PAR_BIT = 0;
    localparam int ERR_ILK_BIT = 2;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [31:0] TARGET_RST = 32'h0000_0000;
    localparam logic [31:0] CAPT_RST   = 32'h0000_0000;
    localparam logic [31:0] READ_ZERO  = 32'h0000_0000;

endpackage

//--- hw/itd_regs.sv
`timescale 1ns/1ps

// Functional notes
// - Target register stores all 32 written bits.
// - Low sixteen bits select interrupt receivers; reset zero.
// - Target bit position equals node number.
// - Interrupt goes to every node with bit set.
// - Capture reloads on each DMA command unless locked or a lock arms that cycle.
// - Interlock read failure freezes capture, sets bit 2.
// - Read-type parity failure freezes capture, sets bit 0.
// - Capture bits 31:30 hold transfer length.
// - Capture bits 29:0 hold longword address.
// - Unlocked capture reads the latest DMA transfer.
// - Capture stays frozen until causing flag clears.
// - Writing one clears interlock flag and unfreezes.
module itd_regs #(
    parameter int NODES  = 16,
    parameter int LEN_W  = 2,
    parameter int ADDR_W = 30
) (
    input  wire logic              mclk,             // Core clock, 100 MHz.
    input  wire logic              rst_n,            // Asynchronous reset, active low.
    input  wire logic [7:0]        ns_addr,          // Node-space register offset.
    input  wire logic              ns_wr,            // One-cycle write strobe.
    input  wire logic              ns_rd,            // One-cycle read strobe.
    input  wire logic [31:0]       ns_wdata,         // Write data.
    output logic      [31:0]       ns_rdata,         // Read data, valid with ns_rack.
    output logic                   ns_rack,          // Read answer pulse.
    input  wire logic              ca_valid,         // DMA command cycle latched.
    input  wire logic [LEN_W-1:0]  ca_len,           // Length of that command.
    input  wire logic [ADDR_W-1:0] ca_addr,          // Longword address of that command.
    input  wire logic              ilk_fail,         // Interlock read failed pulse.
    input  wire logic              par_err,          // Internal bus parity error pulse.
    input  wire logic              par_err_dma_read, // Parity error hit DMA read data.
    input  wire logic              irq_req,          // Request to issue an interrupt.
    output logic                   irq_tx_valid,     // Interrupt transaction pulse.
    output logic      [NODES-1:0]  irq_tx_dest,      // One bit per targeted node.
    output logic                   ilk_flag,         // Interlock read failed flag.
    output logic                   par_flag          // Parity error flag.
);

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    logic                    tgt_wr;
    logic                    err_wr;
    logic [31:0]             tgt_q;
    logic [LEN_W+ADDR_W-1:0] capt_q;
    logic                    par_lock;
    logic                    locked;
    logic                    capt_load;
    logic                    ilk_clr;
    logic                    par_clr;
    logic                    par_lock_set;

    assign tgt_wr       = ns_wr && (ns_addr == itd_pkg::OFS_TARGET_SEL);
    assign err_wr       = ns_wr && (ns_addr == itd_pkg::OFS_ERR_FLAGS);
    assign ilk_clr      = err_wr && ns_wdata[itd_pkg::ERR_ILK_BIT];
    assign par_clr      = err_wr && ns_wdata[itd_pkg::ERR_PAR_BIT];
    assign par_lock_set = par_err && par_err_dma_read;
    assign locked       = ilk_flag || par_lock;

    // A failure in the same cycle as a new command keeps the old capture:
    // the failing transfer is the one already held, not the arriving one.
    assign capt_load = ca_valid && !locked && !ilk_fail && !par_lock_set;

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    itd_target_reg #(
        .WIDTH   (itd_pkg::REG_W)
    ) u_target (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .wr_en   (tgt_wr),
        .wr_data (ns_wdata),
        .value   (tgt_q)
    );

    itd_capture_reg #(
        .LEN_W  (LEN_W),
        .ADDR_W (ADDR_W)
    ) u_capture (
        .mclk   (mclk),
        .rst_n  (rst_n),
        .load   (capt_load),
        .len    (ca_len),
        .addr   (ca_addr),
        .value  (capt_q)
    );

    // ------------------------------------------------------------------
    // Error flags and capture lock
    // ------------------------------------------------------------------
    // A new failure in the clearing cycle wins, so no event is lost.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ilk_flag <= 1'b0;
        end
        else if (ilk_fail)
        begin
            ilk_flag <= 1'b1;
        end
        else if (ilk_clr)
        begin
            ilk_flag <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            par_flag <= 1'b0;
        end
        else if (par_err)
        begin
            par_flag <= 1'b1;
        end
        else if (par_clr)
        begin
            par_flag <= 1'b0;
        end
    end

    // Only a parity error on DMA read data freezes the capture; other
    // parity errors set the flag but leave the capture running.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            par_lock <= 1'b0;
        end
        else if (par_lock_set)
        begin
            par_lock <= 1'b1;
        end
        else if (par_clr)
        begin
            par_lock <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ns_rack <= 1'b0;
        end
        else
        begin
            ns_rack <= ns_rd;
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ns_rdata <= itd_pkg::READ_ZERO;
        end
        else if (ns_rd)
        begin
            unique case (ns_addr)
                itd_pkg::OFS_TARGET_SEL:
                begin
                    ns_rdata <= tgt_q;
                end
                itd_pkg::OFS_DMA_CAPT:
                begin
                    ns_rdata <= capt_q;
                end
                itd_pkg::OFS_ERR_FLAGS:
                begin
                    ns_rdata                       <= itd_pkg::READ_ZERO;
                    ns_rdata[itd_pkg::ERR_ILK_BIT] <= ilk_flag;
                    ns_rdata[itd_pkg::ERR_PAR_BIT] <= par_flag;
                end
                default:
                begin
                    ns_rdata <= itd_pkg::READ_ZERO;
                end
            endcase
        end
        else
        begin
            ns_rdata <= itd_pkg::READ_ZERO;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt transaction
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_tx_valid <= 1'b0;
        end
        else
        begin
            irq_tx_valid <= irq_req;
        end
    end

    // Several bits may be set together; one transaction reaches all.
    for (genvar n = 0; n < NODES; n++)
    begin : g_node
        always_ff @(posedge mclk or negedge rst_n)
        begin
            if (!rst_n)
            begin
                irq_tx_dest[n] <= 1'b0;
            end
            else if (irq_req)
            begin
                irq_tx_dest[n] <= tgt_q[n];
            end
            else
            begin
                irq_tx_dest[n] <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    // Failure events, command cycles and strobes all come from logic on
    // this same clock, so no synchroniser stands in front of them and the
    // properties below may look at them directly.
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    // A parity lock arming in the clearing cycle would keep the capture
    // frozen, so the release sequence excludes it as well.
    sequence s_ilk_cleared;
        ilk_clr && !ilk_fail && !par_lock && !par_lock_set;
    endsequence

    sequence s_fresh_command;
        ca_valid && !ilk_fail && !par_lock_set;
    endsequence

    tgt_write_a: assert property (tgt_wr |=> tgt_q == $past(ns_wdata))
        else $error("target register did not store written word");

    tgt_read_a: assert property (ns_rd && ns_addr == itd_pkg::OFS_TARGET_SEL
                                 |=> ns_rack && ns_rdata == $past(tgt_q))
        else $error("target register read returned wrong data");

    tgt_reset_a: assert property ($rose(rst_n) |-> tgt_q[NODES-1:0] == '0)
        else $error("target field not zero after reset");

    irq_dest_a: assert property (irq_req |=> irq_tx_valid
                                 && irq_tx_dest == $past(tgt_q[NODES-1:0]))
        else $error("interrupt destinations differ from target field");

    irq_idle_a: assert property (!irq_tx_valid |-> irq_tx_dest == '0)
        else $error("destinations driven without a transaction");

    capt_load_a: assert property (ca_valid && !locked && !ilk_fail && !par_lock_set
                                  |=> capt_q == {$past(ca_len), $past(ca_addr)})
        else $error("capture did not load the command");

    capt_hold_a: assert property (locked |=> $stable(capt_q))
        else $error("capture changed while locked");

    // Software may clear the flag in the very cycle it first reads high,
    // so the second step also accepts a clear that was just taken.
    ilk_set_a: assert property (ilk_fail |=> ilk_flag && locked
                                ##1 (locked || $past(ilk_clr)))
        else $error("interlock failure did not set flag and lock");

    par_set_a: assert property (par_lock_set |=> par_flag && par_lock)
        else $error("parity failure did not set flag and lock");

    ilk_clear_a: assert property (s_ilk_cleared ##1 s_fresh_command
                                  |=> !ilk_flag && capt_q == {$past(ca_len), $past(ca_addr)})
        else $error("clearing interlock flag did not release capture");

    capt_read_a: assert property (ns_rd && ns_addr == itd_pkg::OFS_DMA_CAPT
                                  |=> ns_rdata == $past(capt_q))
        else $error("capture read returned wrong data");

    capt_fields_a: assert property (capt_load |=>
        capt_q[LEN_W+ADDR_W-1:itd_pkg::CAPT_LEN_LO] == $past(ca_len)
        && capt_q[ADDR_W-1:0] == $past(ca_addr))
        else $error("length or address misplaced in capture");

    // A parity error on anything but DMA read data must leave the
    // capture running; only the flag records it.
    sequence s_par_no_lock;
        par_err && !par_err_dma_read && !par_lock;
    endsequence

    par_nolock_a: assert property (s_par_no_lock |=> par_flag && !par_lock)
        else $error("parity error outside DMA read locked the capture");

    flags_read_a: assert property (ns_rd && ns_addr == itd_pkg::OFS_ERR_FLAGS
                                   |=> ns_rdata[itd_pkg::ERR_ILK_BIT] == $past(ilk_flag)
                                   && ns_rdata[itd_pkg::ERR_PAR_BIT] == $past(par_flag))
        else $error("error flag read returned wrong data");

    rdata_idle_a: assert property (!ns_rack |-> ns_rdata == itd_pkg::READ_ZERO)
        else $error("read data driven without a read answer");

    ilk_clr_a: assert property (ilk_clr && !ilk_fail |=> !ilk_flag)
        else $error("interlock flag not cleared by a write of one");

endmodule

//--- hw/itd_target_reg.sv
`timescale 1ns/1ps

// Full-width read/write register; the low field doubles as the
// interrupt receiver mask.
module itd_target_reg #(
    parameter int WIDTH = 32
) (
    input  wire logic             mclk,    // Core clock.
    input  wire logic             rst_n,   // Asynchronous reset, active low.
    input  wire logic             wr_en,   // One-cycle write strobe.
    input  wire logic [WIDTH-1:0] wr_data, // Write data.
    output logic      [WIDTH-1:0] value    // Stored value.
);

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    // Upper bits carry no reset meaning, but a constant is loaded anyway
    // so that simulation never sees unknowns leak into read data.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            value <= itd_pkg::TARGET_RST[WIDTH-1:0];
        end
        else if (wr_en)
        begin
            value <= wr_data;
        end
    end

endmodule
